/* rtl/tbcp_device.sv */
// Purpose: parse two command words ahead of each buffer and pass payload
// Assumes: host keeps ordering and consistency across buffers
// Notes: payload bytes leave with byte enables; pads never leave
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// RULE1 - host writes commands before buffer data
// RULE2 - two command words steer each buffer
// RULE3 - tag returned in packet status word
// RULE4 - host sends both words every buffer
// RULE5 - host repeats second word across packet
// RULE6 - differing second words raise transmit error
// RULE7 - completion bit raises buffer loaded flag
// RULE8 - host writes zero reserved bits
// RULE9 - end alignment pads discarded by device
// RULE10 - only payload words stored in fifo
// RULE11 - payload starts at data start offset
// RULE12 - tag sits in upper second word
// RULE13 - first, second word commands, then payload
module tbcp_device (
   input wire logic core_clk,
   input wire logic rst_b,
   tbcp_if.device link,
   output logic fifo_wr,
   output logic [31:0] fifo_data,
   output logic [3:0] fifo_be,
   output logic fifo_last,
   output logic status_wr,
   output logic [15:0] status_tag,
   output logic buffer_loaded_flag,
   output logic transmit_error_flag
);
   tbcp_pkg::tbcp_state_t state;
   tbcp_pkg::tbcp_state_t next_state;
   logic [31:0] cmd_a;
   logic [31:0] cmd_b;
   logic [31:0] pkt_b;
   logic in_pkt;
   logic [9:0] word_cnt;
   logic [9:0] total_words;
   logic [9:0] data_words;
   logic [1:0] lead_bytes;
   logic [1:0] tail_bytes;
   logic [2:0] skip_words;
   logic [10:0] body_end;
   logic a_wr;
   logic b_wr;
   logic d_wr;
   logic in_data;
   logic is_first_data;
   logic is_last_data;
   logic last_word;
   logic b_mismatch;
   logic [3:0] lead_be;
   logic [3:0] tail_be;
   logic pkt_restart;
   logic [31:0] next_pkt_b;
   logic empty_buf;
   logic buf_end;

   // body size in words; the reserved alignment code acts as 4-byte
   tbcp_align u_align (
      .size_bytes(cmd_a[tbcp_pkg::A_SIZE_HI:tbcp_pkg::A_SIZE_LO]),
      .offset_bytes(cmd_a[tbcp_pkg::A_OFS_HI:tbcp_pkg::A_OFS_LO]),
      .align_sel(cmd_a[tbcp_pkg::A_ALIGN_HI:tbcp_pkg::A_ALIGN_LO]),
      .total_words(total_words),
      .data_words(data_words)
   );

   // word role decode from the sequencer state
   assign a_wr = link.wr && (state == tbcp_pkg::TBCP_CMD_A); // see RULE13
   assign b_wr = link.wr && (state == tbcp_pkg::TBCP_CMD_B); // see RULE13
   assign d_wr = link.wr && ((state == tbcp_pkg::TBCP_BODY) ||
      (state == tbcp_pkg::TBCP_PAD));
   assign last_word = (word_cnt + 10'h001) >= total_words;
   assign lead_bytes = cmd_a[tbcp_pkg::A_OFS_LO+1:tbcp_pkg::A_OFS_LO];
   assign skip_words = cmd_a[tbcp_pkg::A_OFS_HI:tbcp_pkg::A_OFS_LO+2];
   assign body_end = cmd_a[tbcp_pkg::A_SIZE_HI:tbcp_pkg::A_SIZE_LO] +
      {9'h000, lead_bytes};
   assign tail_bytes = body_end[1:0];
   // words ahead of the offset and pads past the data are dropped
   assign in_data = (word_cnt >= {7'h00, skip_words}) &&
      (word_cnt < data_words); // see RULE11 see RULE10
   assign is_first_data = word_cnt == {7'h00, skip_words};
   assign is_last_data = (word_cnt + 10'h001) == data_words;
   // byte enables trim bytes before the offset and after the end
   assign lead_be = 4'hf << lead_bytes; // see RULE11
   assign tail_be = (tail_bytes == 2'h0) ? 4'hf :
      (4'hf >> (3'h4 - {1'b0, tail_bytes}));
   // mismatch of second word inside a running packet
   assign b_mismatch = b_wr && in_pkt &&
      (link.wdata != pkt_b); // see RULE6
   // reference second word; a first segment restarts it for later segments, but
   // its own second word is still checked against a packet cut short before it
   assign pkt_restart = b_wr && (!in_pkt || cmd_a[tbcp_pkg::A_FIRST_BIT]);
   assign next_pkt_b = pkt_restart ? link.wdata : pkt_b;
   // a zero-size buffer at offset 0 ends on its second command word
   assign empty_buf = b_wr && (total_words == 10'h000);
   assign buf_end = (d_wr && last_word) || empty_buf; // see RULE9

   // next state of the word sequencer
   always_comb begin
      next_state = state;
      case (state)
         tbcp_pkg::TBCP_CMD_A: begin
            if (link.wr) begin
               next_state = tbcp_pkg::TBCP_CMD_B;
            end
         end
         tbcp_pkg::TBCP_CMD_B: begin
            // an empty buffer has no body; next word is a new command
            if (link.wr) begin
               next_state = (total_words == 10'h000) ?
                  tbcp_pkg::TBCP_CMD_A : tbcp_pkg::TBCP_BODY;
            end
         end
         tbcp_pkg::TBCP_BODY: begin
            if (d_wr) begin
               if (last_word) begin
                  next_state = tbcp_pkg::TBCP_CMD_A;
               end else if ((word_cnt + 10'h001) >= data_words) begin
                  next_state = tbcp_pkg::TBCP_PAD; // see RULE9
               end
            end
         end
         tbcp_pkg::TBCP_PAD: begin
            // pads only advance the count; they never reach the fifo
            if (d_wr && last_word) begin
               next_state = tbcp_pkg::TBCP_CMD_A;
            end
         end
         default: next_state = tbcp_pkg::TBCP_CMD_A;
      endcase
   end

   // sequencer and word counter
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= tbcp_pkg::TBCP_CMD_A;
         word_cnt <= 10'h000;
      end else begin
         state <= next_state;
         if (b_wr) begin
            word_cnt <= 10'h000;
         end else if (d_wr) begin
            word_cnt <= word_cnt + 10'h001;
         end
      end
   end

   // command capture; packet context spans buffers until last segment
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_a <= 32'h0000_0000;
         cmd_b <= 32'h0000_0000;
         pkt_b <= 32'h0000_0000;
         in_pkt <= 1'b0;
      end else begin
         if (a_wr) begin
            cmd_a <= link.wdata; // see RULE2
         end
         pkt_b <= next_pkt_b; // see RULE6
         if (b_wr) begin
            cmd_b <= link.wdata; // see RULE2
            in_pkt <= !cmd_a[tbcp_pkg::A_LAST_BIT];
         end
      end
   end

   // payload out, only kept words reach the fifo
   // data and enables load every cycle; only the strobe qualifies them
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo_wr <= 1'b0;
         fifo_data <= 32'h0000_0000;
         fifo_be <= 4'h0;
         fifo_last <= 1'b0;
      end else begin
         fifo_wr <= (state == tbcp_pkg::TBCP_BODY) && d_wr &&
            in_data; // see RULE10
         fifo_data <= link.wdata;
         fifo_be <= (is_first_data ? lead_be : 4'hf) &
            (is_last_data ? tail_be : 4'hf);
         fifo_last <= is_last_data && cmd_a[tbcp_pkg::A_LAST_BIT];
      end
   end

   // flags and status; done fires on last word incl. pads
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         buffer_loaded_flag <= 1'b0;
         transmit_error_flag <= 1'b0;
         status_wr <= 1'b0;
         status_tag <= 16'h0000;
      end else begin
         buffer_loaded_flag <= cmd_a[tbcp_pkg::A_IOC_BIT] &&
            buf_end; // see RULE7
         transmit_error_flag <= b_mismatch; // see RULE6
         // status only once a packet's last segment has fully arrived
         status_wr <= buf_end && cmd_a[tbcp_pkg::A_LAST_BIT];
         status_tag <=
            next_pkt_b[tbcp_pkg::B_TAG_HI:tbcp_pkg::B_TAG_LO]; // see RULE3
      end
   end

   // the link carries the same pulses back into the host status
   assign link.done_pulse = buffer_loaded_flag;
   assign link.err_pulse = transmit_error_flag;
endmodule // tbcp_device

/* rtl/tbcp_pkg.sv */
// Purpose: shared constants for the transmit command parser link
// Assumes: 32-bit data words, one clock
// Notes: field positions of both command words and status layout
package tbcp_pkg;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned TAG_W = 16;
   localparam int unsigned LEN_W = 11;
   // first command word fields
   localparam int unsigned A_IOC_BIT = 31;
   localparam int unsigned A_RSV_HI = 30;
   localparam int unsigned A_RSV_LO = 26;
   localparam int unsigned A_ALIGN_HI = 25;
   localparam int unsigned A_ALIGN_LO = 24;
   localparam int unsigned A_OFS_HI = 20;
   localparam int unsigned A_OFS_LO = 16;
   localparam int unsigned A_FIRST_BIT = 13;
   localparam int unsigned A_LAST_BIT = 12;
   localparam int unsigned A_SIZE_HI = 10;
   localparam int unsigned A_SIZE_LO = 0;
   // second command word fields
   localparam int unsigned B_TAG_HI = 31;
   localparam int unsigned B_TAG_LO = 16;
   localparam int unsigned B_LEN_HI = 10;
   localparam int unsigned B_LEN_LO = 0;
   // end alignment encodings, in words
   localparam logic [1:0] ALIGN_4B = 2'h0;
   localparam logic [1:0] ALIGN_16B = 2'h1;
   localparam logic [1:0] ALIGN_32B = 2'h2;
   localparam logic [3:0] WORDS_16B = 4'h4;
   localparam logic [3:0] WORDS_32B = 4'h8;
   // controller register offsets (host side)
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_TAG = 4'hc;
   localparam logic [1:0] STATUS_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   typedef enum logic [1:0] {
      TBCP_CMD_A = 2'b00,
      TBCP_CMD_B = 2'b01,
      TBCP_BODY = 2'b11,
      TBCP_PAD = 2'b10
   } tbcp_state_t;
endpackage

/* rtl/tbcp_if.sv */
// Purpose: word link from host writer to transmit fifo front end
// Assumes: single clock, writer never stalled
// Notes: done and error are one-cycle pulses from the device
`timescale 1ns/1ps
interface tbcp_if;
   logic wr;
   logic [31:0] wdata;
   logic done_pulse;
   logic err_pulse;
   modport device (input wr, input wdata, output done_pulse,
      output err_pulse);
   modport host (output wr, output wdata, input done_pulse,
      input err_pulse);
endinterface

/* rtl/tbcp_align.sv */
// Purpose: word count of a buffer body rounded up to its end alignment
// Assumes: byte size plus start offset fits in 12 bits
// Notes: pure combinational helper
`timescale 1ns/1ps
module tbcp_align (
   input wire logic [10:0] size_bytes,
   input wire logic [4:0] offset_bytes,
   input wire logic [1:0] align_sel,
   output logic [9:0] total_words,
   output logic [9:0] data_words
);
   logic [11:0] span;
   logic [9:0] raw;
   // bytes before the offset still occupy written words
   assign span = {1'b0, size_bytes} + {7'h00, offset_bytes};
   assign raw = 10'(({1'b0, span} + 13'h0003) >> 2);
   assign data_words = raw;
   // round up to 4 or 8 words; reserved code behaves as one word
   assign total_words = (align_sel == tbcp_pkg::ALIGN_16B) ?
      ((raw + 10'h003) & 10'h3fc) :
      (align_sel == tbcp_pkg::ALIGN_32B) ?
      ((raw + 10'h007) & 10'h3f8) : raw;
endmodule // tbcp_align

/* rtl/tbcp_host.sv */
// Purpose: host side writer of command and payload words
// Assumes: software orders words; writer only forwards them
// Notes: sticky status with write-one-to-clear and a mask
`timescale 1ns/1ps
module tbcp_host (
   input wire logic core_clk,
   input wire logic rst_b,
   tbcp_if.host link,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   output logic irq
);
   logic [1:0] status;
   logic [1:0] mask;
   logic [1:0] events;
   logic [1:0] w1c;
   logic [31:0] last_tag;
   logic sel_status;
   logic sel_mask;
   logic sel_data;
   logic sel_tag;

   // address decode
   assign sel_status = addr == tbcp_pkg::REG_STATUS;
   assign sel_mask = addr == tbcp_pkg::REG_MASK;
   assign sel_data = addr == tbcp_pkg::REG_DATA;
   assign sel_tag = addr == tbcp_pkg::REG_TAG;
   assign events = {link.err_pulse, link.done_pulse};
   assign w1c = (wr_stb && sel_status) ? wdata[1:0] : 2'h0;
   assign irq = |(status & ~mask); // a set mask bit blocks its status bit

   // software word goes straight to the link, one per write
   // command words must come first; software owns that order (see RULE1)
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         link.wr <= 1'b0;
         link.wdata <= 32'h0000_0000;
      end else begin
         link.wr <= wr_stb && sel_data; // see RULE4 see RULE5
         link.wdata <= wdata; // see RULE8 see RULE12
      end
   end

   // sticky status: a new event beats a same-cycle clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= tbcp_pkg::STATUS_RST;
         mask <= tbcp_pkg::MASK_RST;
         last_tag <= 32'h0000_0000;
         rdata <= 32'h0000_0000;
      end else begin
         status <= (status & ~w1c) | events;
         if (wr_stb && sel_mask) begin
            mask <= wdata[1:0];
         end
         if (wr_stb && sel_data) begin
            last_tag <= wdata;
         end
         if (rd_stb && sel_status) begin
            rdata <= {30'h0, status};
         end else if (rd_stb && sel_mask) begin
            rdata <= {30'h0, mask};
         end else if (rd_stb && sel_tag) begin
            rdata <= last_tag;
         end else begin
            rdata <= 32'h0000_0000;
         end
      end
   end
endmodule // tbcp_host

/* tb/tbcp_checker.sv */
// Purpose: link checks for the transmit command parser
// Assumes: one clock, async active-low reset
// Notes: words counted since reset to find the command slots
`timescale 1ns/1ps
module tbcp_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic wr,
   input wire logic [31:0] wdata,
   input wire logic done_pulse,
   input wire logic err_pulse
);
   logic [1:0] word_cnt;
   logic [1:0] next_word_cnt;
   // saturates so long runs never wrap back into the command slots
   assign next_word_cnt = (wr && word_cnt != 2'h3) ? word_cnt + 2'h1
      : word_cnt;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) word_cnt <= 2'h0;
      else word_cnt <= next_word_cnt;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_done_one_cycle: assert property (
      done_pulse |=> !done_pulse) else $error("done pulse too long");
   a_err_one_cycle: assert property (
      err_pulse |=> !err_pulse) else $error("error pulse too long");
   a_done_after_word: assert property (
      done_pulse |-> $past(wr)) else $error("done without a word");
   a_err_after_word: assert property (
      err_pulse |-> $past(wr)) else $error("error without a word");
   a_err_after_cmds: assert property (
      err_pulse |-> word_cnt >= 2'h2) else $error("error before word two");
   a_done_after_cmds: assert property (
      done_pulse |-> word_cnt >= 2'h2) else $error("done before word two");
   a_quiet_release: assert property (
      $rose(rst_b) |-> !done_pulse && !err_pulse)
      else $error("pulse at reset release");
   a_idle_no_pulse: assert property (
      (!wr) [*2] |-> !done_pulse && !err_pulse)
      else $error("pulse on an idle link");
endmodule // tbcp_checker

/* tb/tx_buffer_command_parser_test.sv */
// Purpose: host-to-device run of command parsing and payload flow
// Assumes: mask bit set blocks the matching status bit
// Notes: payload words and status tags are queued by a monitor
`timescale 1ns/1ps
module tx_buffer_command_parser_test;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [31:0] rdata, fifo_data;
   logic irq, fifo_wr, fifo_last, status_wr, done_flag, err_flag;
   logic [3:0] fifo_be;
   logic [15:0] status_tag;
   logic [31:0] fq[$];
   logic [3:0] bq[$];
   logic lq[$];
   logic [15:0] tq[$];
   int error_cnt = 0;
   int tests_run = 0;
   tbcp_if link ();
   always #2.5 core_clk = ~core_clk;
   tbcp_host i_tbcp_host (.core_clk(core_clk), .rst_b(rst_b), .link(link),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .irq(irq));
   tbcp_device i_tbcp_device (.core_clk(core_clk), .rst_b(rst_b),
      .link(link), .fifo_wr(fifo_wr), .fifo_data(fifo_data),
      .fifo_be(fifo_be), .fifo_last(fifo_last), .status_wr(status_wr),
      .status_tag(status_tag), .buffer_loaded_flag(done_flag),
      .transmit_error_flag(err_flag));
   tbcp_checker i_tbcp_checker (.core_clk(core_clk), .rst_b(rst_b),
      .wr(link.wr), .wdata(link.wdata), .done_pulse(link.done_pulse),
      .err_pulse(link.err_pulse));
   // monitor keeps every payload word and status tag
   always @(posedge core_clk) begin
      if (fifo_wr) begin
         fq.push_back(fifo_data);
         bq.push_back(fifo_be);
         lq.push_back(fifo_last);
      end
      if (status_wr) tq.push_back(status_tag);
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask
   // read data is only valid the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
      input string what);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask
   function automatic logic [31:0] mk_a(input logic ioc,
      input logic [1:0] al, input logic [4:0] ofs, input logic fs,
      input logic ls, input logic [10:0] sz);
      mk_a = {ioc, 5'h0, al, 3'h0, ofs, 2'h0, fs, ls, 1'b0, sz};
   endfunction
   // command pair, then n payload or pad words
   task automatic send(input logic [31:0] a, input logic [31:0] b,
      input int n);
      wr_reg(4'h8, a);
      wr_reg(4'h8, b);
      for (int i = 0; i < n; i++) wr_reg(4'h8, 32'hd000_0000 + i);
      repeat (3) @(posedge core_clk);
   endtask
   task automatic clr();
      fq.delete();
      bq.delete();
      lq.delete();
      tq.delete();
      wr_reg(4'h0, 32'h3);
   endtask
   // a hang counts as a mismatch and ends the run
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      $display("Error watchdog expected done seen hang");
      stop_test();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      rd_chk(4'h0, 32'h0, "status reset");
      rd_chk(4'h4, 32'h0, "mask reset");
      rd_chk(4'h2, 32'h0, "unmapped");
      $display("test reset done");
      // offset 5 drops word 0, 16-byte end leaves one pad word
      send(mk_a(1'b1, 2'h1, 5'h5, 1'b1, 1'b1, 11'h6), 32'ha5a5_0006, 4);
      chk("word count", 32'h2, fq.size());
      chk("first word", 32'hd000_0001, fq[0]);
      chk("first be", 32'he, bq[0]);
      chk("last flag", 32'h1, lq[1]);
      chk("last be", 32'h7, bq[1]);
      chk("tag", 32'ha5a5, tq[0]);
      rd_chk(4'h0, 32'h1, "done bit");
      chk("irq open", 32'h1, irq);
      wr_reg(4'h4, 32'h3);
      #1 chk("irq masked", 32'h0, irq);
      wr_reg(4'h4, 32'h0);
      clr();
      rd_chk(4'h0, 32'h0, "status cleared");
      $display("test single buffer done");
      // two buffers of one packet with differing second words
      send(mk_a(1'b0, 2'h0, 5'h0, 1'b1, 1'b0, 11'h4), 32'h1111_0008, 1);
      send(mk_a(1'b0, 2'h0, 5'h0, 1'b0, 1'b1, 11'h4), 32'h2222_0008, 1);
      rd_chk(4'h0, 32'h2, "error bit");
      chk("split words", 32'h2, fq.size());
      clr();
      $display("test mismatch done");
      // same packet split with matching second words
      send(mk_a(1'b1, 2'h0, 5'h0, 1'b1, 1'b0, 11'h4), 32'h3c3c_0008, 1);
      send(mk_a(1'b1, 2'h0, 5'h0, 1'b0, 1'b1, 11'h4), 32'h3c3c_0008, 1);
      rd_chk(4'h0, 32'h1, "no error");
      chk("mid flag", 32'h0, lq[0]);
      chk("end flag", 32'h1, lq[1]);
      chk("split tag", 32'h3c3c, tq[0]);
      clr();
      $display("test matching packet done");
      // 32-byte end leaves six pads, then an empty buffer follows
      send(mk_a(1'b1, 2'h2, 5'h0, 1'b1, 1'b1, 11'h8), 32'h7e7e_0008, 8);
      send(mk_a(1'b1, 2'h0, 5'h0, 1'b1, 1'b1, 11'h0), 32'h4242_0000, 0);
      chk("wide words", 32'h2, fq.size());
      chk("wide be", 32'hf, bq[1]);
      chk("wide tag", 32'h7e7e, tq[0]);
      chk("empty tag", 32'h4242, tq[1]);
      rd_chk(4'h0, 32'h1, "wide done");
      clr();
      $display("test wide alignment done");
      stop_test();
   end
endmodule // tx_buffer_command_parser_test
